// ===== verilog/i2cam_top.sv
`timescale 1ns/1ps
`default_nettype none
module i2cam_top #(
   parameter int AW = 12 // AXI address width
) (
   // Clock and reset
   input  wire logic                 mclk_in,
   input  wire logic                 rst_in,
   // AXI4-Lite write address and data
   input  wire logic [AW-1:0]        axi_awaddr_in,
   input  wire logic                 axi_awvalid_in,
   output logic                      axi_awready_out,
   input  wire logic [31:0]          axi_wdata_in,
   input  wire logic [3:0]           axi_wstrb_in,
   input  wire logic                 axi_wvalid_in,
   output logic                      axi_wready_out,
   // AXI4-Lite write response
   output logic [1:0]                axi_bresp_out,
   output logic                      axi_bvalid_out,
   input  wire logic                 axi_bready_in,
   // AXI4-Lite read
   input  wire logic [AW-1:0]        axi_araddr_in,
   input  wire logic                 axi_arvalid_in,
   output logic                      axi_arready_out,
   output logic [31:0]               axi_rdata_out,
   output logic [1:0]                axi_rresp_out,
   output logic                      axi_rvalid_out,
   input  wire logic                 axi_rready_in,
   // Engine side
   input  wire i2cam_pkg::i2cam_evt_t eng_evt_in,
   output logic                      slot3_match_out,
   output logic [9:0]                target_addr_value_out,
   output logic                      module_soft_reset_hold_out,
   output logic                      addr10_mode_out,
   output logic                      master_mode_out,
   // Interrupt
   output logic                      irq_out
);
   import i2cam_pkg::*;

   // Whole state of the block
   typedef struct packed {
      logic          aw_got;      // Write address held
      logic [AW-1:0] awaddr;
      logic          w_got;       // Write data held
      logic [31:0]   wdata;
      logic [3:0]    wstrb;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          rvalid;
      logic [31:0]   rdata;
      logic [1:0]    rresp;
      logic [9:0]    oa3;         // own_addr_slot3_value
      logic          oa3_en;      // slot_match_enable
      logic [9:0]    rxaddr;      // last_seen_address
      logic [9:0]    mask;        // compare_mask_bits
      logic [9:0]    target;      // target_addr_value
      logic          swrst;       // module_soft_reset_hold
      logic          mode10;      // Ten-bit addressing
      logic          master;      // Master mode
      logic          seen;        // Slot three hit in this frame
      logic [1:0]    irq_st;      // Sticky events
      logic [1:0]    irq_msk;     // Event mask
   } i2cam_state_t;

   localparam i2cam_state_t ST_RESET = '{
      aw_got: 1'b0, awaddr: '0, w_got: 1'b0, wdata: 32'h0,
      wstrb: 4'h0, bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0,
      rdata: 32'h0, rresp: RESP_OKAY, oa3: RST_OA3, oa3_en: 1'b0,
      rxaddr: RST_RXADDR, mask: RST_MASK, target: RST_TARGET,
      swrst: RST_SWRST, mode10: 1'b0, master: 1'b0, seen: 1'b0,
      irq_st: RST_IRQST, irq_msk: 2'h0};

   i2cam_state_t state_ff;   // Registered state
   i2cam_state_t nxt_state;  // Next state
   logic [9:0]   cmp_bits;   // Bits that take part in compare
   logic [9:0]   diff_bits;  // Mismatching compared bits
   logic         hit3;       // Slot three matched this cycle
   logic         txf3_set;   // Transmit flag event
   logic [1:0]   irq_set;    // Events this cycle
   logic [1:0]   irq_clr;    // Software clears this cycle

   // Merge a write into a 16-bit register by byte strobes
   // Lanes 2 and 3 carry nothing; upper halves always read zero
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction

   // Read mux over the register map
   // One function keeps the whole map in one place
   // Reserved bits read zero; an unmapped address answers SLVERR
   function automatic logic [32:0] rd_word(input i2cam_state_t s,
                                           input logic [AW-1:0] a);
      logic [32:0] r; // Bit 32 flags an unmapped address
      r = 33'h0;
      unique case (a)
         AW'({IDX_OA3, 2'b00}):    r[10:0] = {s.oa3_en, s.oa3};
         AW'({IDX_RXADDR, 2'b00}): r[9:0]  = s.rxaddr;
         AW'({IDX_MASK, 2'b00}):   r[9:0]  = s.mask;
         AW'({IDX_TARGET, 2'b00}): r[9:0]  = s.target;
         AW'({IDX_CTRL, 2'b00}):   r[2:0]  = {s.master, s.mode10, s.swrst};
         AW'({IDX_IRQST, 2'b00}):  r[1:0]  = s.irq_st;
         AW'({IDX_IRQMSK, 2'b00}): r[1:0]  = s.irq_msk;
         default:                  r[32]   = 1'b1;
      endcase
      return r;
   endfunction

   // Address compare for slot three
   always_comb begin
      // Seven-bit mode ignores bits 9-7
      cmp_bits  = state_ff.mode10 ? CMP_10BIT : CMP_7BIT;
      // Cleared mask bits drop out; all ones means exact match
      diff_bits = (eng_evt_in.addr ^ state_ff.oa3) & state_ff.mask & cmp_bits;
      // The live pulse is compared, so the hit shows one edge later
      // Disabled slot or held module never matches
      hit3 = eng_evt_in.addr_valid && state_ff.oa3_en && !state_ff.swrst
             && (diff_bits == 10'h000);
      // Transmit flag needs this frame's hit and an empty buffer
      txf3_set = eng_evt_in.tx_empty && eng_evt_in.slave_mode
                 && state_ff.seen && !state_ff.swrst;
      // Both events go to the sticky status register
      irq_set           = 2'h0;
      irq_set[POS_TXF3] = txf3_set;
      irq_set[POS_HIT3] = hit3;
   end

   // Next state
   // Each write channel is taken once and answered when both halves are held;
   // both are released as the response rises, and the next pair is written only after it retires
   always_comb begin
      logic [15:0] wv;  // Merged write value
      logic [32:0] rw;  // Read word with unmapped flag
      logic        do_wr;
      nxt_state = state_ff;
      wv        = 16'h0;
      rw        = 33'h0;
      irq_clr   = 2'h0;
      do_wr     = state_ff.aw_got && state_ff.w_got && !state_ff.bvalid;
      // Address and data are taken in either order
      if (axi_awvalid_in && !state_ff.aw_got) begin
         nxt_state.aw_got = 1'b1;
         nxt_state.awaddr = axi_awaddr_in;
      end
      if (axi_wvalid_in && !state_ff.w_got) begin
         nxt_state.w_got = 1'b1;
         nxt_state.wdata = axi_wdata_in;
         nxt_state.wstrb = axi_wstrb_in;
      end
      // Response retires on bready
      if (state_ff.bvalid && axi_bready_in) begin
         nxt_state.bvalid = 1'b0;
      end
      // Register write once both halves are held
      if (do_wr) begin
         nxt_state.aw_got = 1'b0;
         nxt_state.w_got  = 1'b0;
         nxt_state.bvalid = 1'b1;
         nxt_state.bresp  = RESP_OKAY;
         unique case (state_ff.awaddr)
            AW'({IDX_OA3, 2'b00}): begin
               wv = merge16({5'h0, state_ff.oa3_en, state_ff.oa3},
                            state_ff.wdata, state_ff.wstrb);
               // Outside soft reset the write is dropped silently
               if (state_ff.swrst) begin
                  nxt_state.oa3    = wv[9:0];
                  nxt_state.oa3_en = wv[POS_EN];
               end
            end
            AW'({IDX_RXADDR, 2'b00}): begin
               // Read-only, write ignored
               nxt_state.bresp = RESP_OKAY;
            end
            AW'({IDX_MASK, 2'b00}): begin
               wv = merge16({6'h0, state_ff.mask}, state_ff.wdata, state_ff.wstrb);
               if (state_ff.swrst) begin
                  nxt_state.mask = wv[9:0];
               end
            end
            AW'({IDX_TARGET, 2'b00}): begin
               // Not protected: it is only used while acting as master
               wv = merge16({6'h0, state_ff.target}, state_ff.wdata, state_ff.wstrb);
               nxt_state.target = wv[9:0];
            end
            AW'({IDX_CTRL, 2'b00}): begin
               // Never protected, or soft reset could not be left again
               if (state_ff.wstrb[0]) begin
                  nxt_state.swrst  = state_ff.wdata[POS_SWRST];
                  nxt_state.mode10 = state_ff.wdata[POS_MODE10];
                  nxt_state.master = state_ff.wdata[POS_MASTER];
               end
            end
            AW'({IDX_IRQST, 2'b00}): begin
               // Write one to clear
               if (state_ff.wstrb[0]) begin
                  irq_clr = state_ff.wdata[1:0];
               end
            end
            AW'({IDX_IRQMSK, 2'b00}): begin
               // The level output follows the new mask one edge later
               if (state_ff.wstrb[0]) begin
                  nxt_state.irq_msk = state_ff.wdata[1:0];
               end
            end
            default: begin
               nxt_state.bresp = RESP_SLVERR;
            end
         endcase
      end
      // Read: one outstanding, data registered
      // A new read waits until the previous answer is taken
      if (state_ff.rvalid && axi_rready_in) begin
         nxt_state.rvalid = 1'b0;
      end
      if (axi_arvalid_in && !state_ff.rvalid) begin
         rw               = rd_word(state_ff, axi_araddr_in);
         nxt_state.rvalid = 1'b1;
         nxt_state.rdata  = rw[31:0];
         nxt_state.rresp  = rw[32] ? RESP_SLVERR : RESP_OKAY;
      end
      // Every address seen on the bus is recorded
      if (eng_evt_in.addr_valid) begin
         nxt_state.rxaddr = eng_evt_in.addr;
      end
      // Frame hit memory; a new hit wins over the stop
      // Soft reset forgets the hit too, so a new setup starts clean
      if (eng_evt_in.frame_end || state_ff.swrst) begin
         nxt_state.seen = 1'b0;
      end
      if (hit3) begin
         nxt_state.seen = 1'b1;
      end
      // Set wins over a clear in the same cycle
      nxt_state.irq_st = (state_ff.irq_st & ~irq_clr) | irq_set;
   end

   // State register
   // Synchronous reset; the soft reset hold comes up set
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         state_ff <= ST_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Bus handshakes
   // A ready is low while its channel already holds an item
   assign axi_awready_out = !state_ff.aw_got;
   assign axi_wready_out  = !state_ff.w_got;
   assign axi_arready_out = !state_ff.rvalid;
   assign axi_bvalid_out  = state_ff.bvalid;
   assign axi_bresp_out   = state_ff.bresp;
   assign axi_rvalid_out  = state_ff.rvalid;
   assign axi_rdata_out   = state_ff.rdata;
   assign axi_rresp_out   = state_ff.rresp;

   // Engine outputs; target is zero unless acting as master
   assign target_addr_value_out = state_ff.master
                                  ? (state_ff.target & (state_ff.mode10 ? CMP_10BIT : CMP_7BIT))
                                  : 10'h000;
   assign slot3_match_out            = state_ff.seen;
   assign module_soft_reset_hold_out = state_ff.swrst;
   assign addr10_mode_out            = state_ff.mode10;
   assign master_mode_out            = state_ff.master;
   // Level interrupt while any unmasked flag stands
   assign irq_out = |(state_ff.irq_st & state_ff.irq_msk);

   // Checks
   // They run on the module clock and pause while reset is held
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   // Slot gating and compare

   slot_enable_gate_a: assert property (
      (eng_evt_in.addr_valid && !state_ff.oa3_en && !state_ff.seen)
      |=> !state_ff.seen) else $error("disabled slot matched");
   ten_bit_match_a: assert property (
      (eng_evt_in.addr_valid && state_ff.mode10 && state_ff.oa3_en && !state_ff.swrst
       && eng_evt_in.addr == state_ff.oa3) |=> state_ff.seen)
      else $error("ten-bit exact match missed");
   seven_bit_match_a: assert property (
      (eng_evt_in.addr_valid && !state_ff.mode10 && state_ff.oa3_en && !state_ff.swrst
       && ((eng_evt_in.addr ^ state_ff.oa3) & state_ff.mask & 10'h07F) == 10'h000)
      |=> state_ff.seen) else $error("seven-bit match missed");
   // Protection and capture of the registers
   protect_fields_a: assert property (
      (!$stable(state_ff.oa3) || !$stable(state_ff.mask) || !$stable(state_ff.oa3_en))
      |-> $past(state_ff.swrst)) else $error("protected field changed while running");
   rx_capture_a: assert property (
      eng_evt_in.addr_valid |=> state_ff.rxaddr == $past(eng_evt_in.addr))
      else $error("received address not captured");
   // Mask behaviour
   masked_match_a: assert property (
      (eng_evt_in.addr_valid && state_ff.oa3_en && !state_ff.swrst && state_ff.mask != 10'h3FF
       && ((eng_evt_in.addr ^ state_ff.oa3) & state_ff.mask & cmp_bits) == 10'h000)
      |=> state_ff.seen) else $error("masked address not matched");
   exact_mismatch_a: assert property (
      (eng_evt_in.addr_valid && state_ff.mask == 10'h3FF && !state_ff.seen
       && ((eng_evt_in.addr ^ state_ff.oa3) & cmp_bits) != 10'h000)
      |=> !state_ff.seen) else $error("mismatch accepted with full mask");
   // Target path
   target_master_a: assert property (
      !state_ff.master |-> target_addr_value_out == 10'h000)
      else $error("target driven outside master mode");
   target_seven_a: assert property (
      (state_ff.master && !state_ff.mode10) |-> target_addr_value_out[9:7] == 3'h0)
      else $error("target high bits in seven-bit mode");
   // Interrupt flags and dropped writes
   tx_flag_set_a: assert property (
      (eng_evt_in.tx_empty && eng_evt_in.slave_mode && state_ff.seen && !state_ff.swrst)
      |=> state_ff.irq_st[POS_TXF3]) else $error("transmit flag not set");
   drop_write_a: assert property (
      (!state_ff.swrst && state_ff.aw_got && state_ff.w_got && !state_ff.bvalid)
      |=> $stable(state_ff.mask) && $stable(state_ff.oa3)) else $error("write not dropped");
   // The received address moves only on a bus address
   rx_hold_a: assert property (
      !eng_evt_in.addr_valid |=> $stable(state_ff.rxaddr))
      else $error("received address changed without bus address");
   // A stop without a fresh hit forgets the slot
   frame_clear_a: assert property (
      (eng_evt_in.frame_end && !hit3) |=> !state_ff.seen)
      else $error("slot hit survived the stop");
   // Every hit raises its sticky status bit
   hit_flag_a: assert property (
      hit3 |=> state_ff.irq_st[POS_HIT3]) else $error("hit flag not set");

   // Main scenarios
   write_done_c: cover property (axi_bvalid_out && axi_bready_in);
   slot_hit_c:   cover property (hit3 ##[1:20] eng_evt_in.frame_end);
   irq_rise_c:   cover property ($rose(irq_out));
   masked_hit_c: cover property (hit3 && state_ff.mask != RST_MASK);
   drop_wr_c:    cover property (!state_ff.swrst && state_ff.aw_got && state_ff.w_got);
endmodule // i2cam_top
`default_nettype wire

// ===== verilog/i2cam_pkg.sv
// Notes on behaviour
// - Slot three compared only when enabled
// - Slot three holds right-justified ten-bit address
// - Seven-bit mode compares bits 6-0 only
// - Protected fields change only under soft reset
// - Last bus address captured, read-only, resets zero
// - Cleared mask bits are don't-care in compare
// - Mask resets all ones, exact match
// - Target address used only as master
// - Target address right justified, seven or ten bits
// - Slot three transmit flag on empty buffer
`default_nettype none
package i2cam_pkg;
   // Register indices; byte address is four times the index
   localparam logic [9:0]  IDX_OA3    = 10'h1DA;
   localparam logic [9:0]  IDX_RXADDR = 10'h1DC;
   localparam logic [9:0]  IDX_MASK   = 10'h1DE;
   localparam logic [9:0]  IDX_TARGET = 10'h1E0;
   localparam logic [9:0]  IDX_CTRL   = 10'h1E2;
   localparam logic [9:0]  IDX_IRQST  = 10'h1E4;
   localparam logic [9:0]  IDX_IRQMSK = 10'h1E6;
   // Field positions
   localparam int          POS_EN     = 10;
   localparam int          POS_SWRST  = 0;
   localparam int          POS_MODE10 = 1;
   localparam int          POS_MASTER = 2;
   localparam int          POS_TXF3   = 0;
   localparam int          POS_HIT3   = 1;
   // Reset values
   localparam logic [9:0]  RST_OA3    = 10'h000;
   localparam logic [9:0]  RST_MASK   = 10'h3FF;
   localparam logic [9:0]  RST_TARGET = 10'h000;
   localparam logic [9:0]  RST_RXADDR = 10'h000;
   localparam logic        RST_SWRST  = 1'b1;
   localparam logic [1:0]  RST_IRQST  = 2'h1;
   // Compared bits per addressing mode
   localparam logic [9:0]  CMP_7BIT   = 10'h07F;
   localparam logic [9:0]  CMP_10BIT  = 10'h3FF;
   // AXI responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // Events from the bit-level engine
   typedef struct packed {
      logic       addr_valid; // Pulse: an address was received
      logic [9:0] addr;       // Received address, right justified
      logic       frame_end;  // Pulse: stop seen
      logic       tx_empty;   // Level: holding buffer empty
      logic       slave_mode; // Level: engine acts as slave
   } i2cam_evt_t;
endpackage : i2cam_pkg
`default_nettype wire

// ===== verification/i2cam_eng_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the bit-level engine, which reports what the bus carried
module i2cam_eng_model
   import i2cam_pkg::*;
(
   // Clock
   input  wire logic  mclk_in,
   // Events towards the block
   output var i2cam_pkg::i2cam_evt_t evt_out
);
   // Idle: no pulses, buffer full, not addressed as slave
   initial evt_out = '0;

   // One address pulse; the field is inverted afterwards so nothing leans on a stale value
   task automatic send_addr(input logic [9:0] a);
      @(posedge mclk_in) evt_out.addr_valid <= 1'b1;
      evt_out.addr <= a;
      @(posedge mclk_in) evt_out.addr_valid <= 1'b0;
      evt_out.addr <= ~a;
   endtask

   // Stop condition ends the frame
   task automatic end_frame();
      @(posedge mclk_in) evt_out.frame_end <= 1'b1;
      @(posedge mclk_in) evt_out.frame_end <= 1'b0;
   endtask

   // Slave mode and empty holding buffer, as levels
   task automatic set_tx(input logic slave, input logic empty);
      @(posedge mclk_in) evt_out.slave_mode <= slave;
      evt_out.tx_empty <= empty;
   endtask
endmodule // i2cam_eng_model
`default_nettype wire

// ===== verification/i2cam_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module i2cam_tb_top;
   import i2cam_pkg::*;
   // Byte addresses are four times the register index
   localparam logic [11:0] A_OA3 = {IDX_OA3, 2'b00};
   localparam logic [11:0] A_RX = {IDX_RXADDR, 2'b00};
   localparam logic [11:0] A_MSK = {IDX_MASK, 2'b00};
   localparam logic [11:0] A_TGT = {IDX_TARGET, 2'b00};
   localparam logic [11:0] A_CTL = {IDX_CTRL, 2'b00};
   localparam logic [11:0] A_ST = {IDX_IRQST, 2'b00};
   localparam logic [11:0] A_IM = {IDX_IRQMSK, 2'b00};
   localparam logic [11:0] A_BAD = 12'h7FC; // Unmapped
   logic mclk = 1'b0, rst = 1'b1;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = '0;
   logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
   logic arvalid = 0, arready, rvalid, rready = 0, irq, match, swr, m10, mst;
   logic [1:0] bresp, rresp;
   logic [9:0] tgt;
   i2cam_evt_t evt;
   int fail_count = 0, n_checks = 0;

   // 40 MHz clock
   always #12.5 mclk = ~mclk;

   i2cam_top #(.AW(12)) dut (.mclk_in(mclk), .rst_in(rst),
      .axi_awaddr_in(awaddr), .axi_awvalid_in(awvalid), .axi_awready_out(awready),
      .axi_wdata_in(wdata), .axi_wstrb_in(wstrb), .axi_wvalid_in(wvalid),
      .axi_wready_out(wready), .axi_bresp_out(bresp), .axi_bvalid_out(bvalid),
      .axi_bready_in(bready), .axi_araddr_in(araddr), .axi_arvalid_in(arvalid),
      .axi_arready_out(arready), .axi_rdata_out(rdata), .axi_rresp_out(rresp),
      .axi_rvalid_out(rvalid), .axi_rready_in(rready), .eng_evt_in(evt),
      .slot3_match_out(match), .target_addr_value_out(tgt),
      .module_soft_reset_hold_out(swr), .addr10_mode_out(m10),
      .master_mode_out(mst), .irq_out(irq));
   i2cam_eng_model eng (.mclk_in(mclk), .evt_out(evt));

   // Single comparison point
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // Write with both channels offered together; each dropped once taken
   task automatic w(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
      @(posedge mclk) awaddr <= a;
      wdata <= d;
      wstrb <= 4'h3;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      chk(bresp, er);
   endtask

   // Read and compare data and response
   task automatic r(input logic [11:0] a, input logic [31:0] exp,
                    input logic [1:0] er = RESP_OKAY);
      @(posedge mclk) araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      chk(rdata, exp);
      chk(rresp, er);
   endtask

   // Fresh frame, one address, then look at the slot hit
   task automatic hit(input logic [9:0] a, input logic exp);
      eng.end_frame();
      eng.send_addr(a);
      @(negedge mclk) chk(match, exp);
   endtask

   // Protected fields are set up under soft reset, then the control register is written with c
   task automatic setup(input logic [31:0] oa, input logic [31:0] msk, input logic [31:0] c);
      w(A_CTL, 32'h1);
      w(A_OA3, oa);
      w(A_MSK, msk);
      w(A_CTL, c);
   endtask

   task automatic t_reset();
      r(A_OA3, 32'h0);
      r(A_RX, 32'h0);
      r(A_MSK, 32'h3FF);
      r(A_TGT, 32'h0);
      r(A_ST, 32'h1);
      chk({irq, match, swr}, 3'h1);
   endtask

   // Writes outside soft reset are dropped; read-only and unmapped places
   task automatic t_protect();
      w(A_CTL, 32'h0);
      w(A_OA3, 32'h455);
      w(A_MSK, 32'h000);
      r(A_OA3, 32'h0);
      r(A_MSK, 32'h3FF);
      w(A_RX, 32'h123);
      r(A_RX, 32'h0);
      w(A_BAD, 32'h1, RESP_SLVERR);
      r(A_BAD, 32'h0, RESP_SLVERR);
   endtask

   task automatic t_match7();
      setup(32'h42A, 32'h3FF, 32'h0);
      r(A_OA3, 32'h42A);
      hit(10'h02A, 1'b1);
      r(A_RX, 32'h2A);
      hit(10'h3AA, 1'b1);
      hit(10'h02B, 1'b0);
      r(A_RX, 32'h2B);
   endtask

   task automatic t_mask();
      setup(32'h42A, 32'h3FE, 32'h0);
      hit(10'h02B, 1'b1);
      hit(10'h02C, 1'b0);
   endtask

   // Disabled slot, and no match while soft reset is held
   task automatic t_enable();
      setup(32'h02A, 32'h3FF, 32'h0);
      hit(10'h02A, 1'b0);
      setup(32'h42A, 32'h3FF, 32'h1);
      hit(10'h02A, 1'b0);
   endtask

   task automatic t_ten();
      setup(32'h62A, 32'h3FF, 32'h2);
      @(negedge mclk) chk(m10, 1'b1);
      hit(10'h02A, 1'b0);
      hit(10'h22A, 1'b1);
   endtask

   // Flag sets only with a hit in this frame and an empty buffer in slave mode
   task automatic t_irq();
      r(A_ST, 32'h3);
      w(A_ST, 32'h3);
      r(A_ST, 32'h0);
      w(A_IM, 32'h1);
      @(negedge mclk) chk(irq, 1'b0);
      eng.set_tx(1'b1, 1'b1);
      repeat (2) @(negedge mclk);
      r(A_ST, 32'h1);
      chk(irq, 1'b1);
      eng.set_tx(1'b0, 1'b0);
      w(A_ST, 32'h1);
      @(negedge mclk) chk(irq, 1'b0);
      eng.end_frame();
      w(A_IM, 32'h0);
   endtask

   task automatic t_target();
      w(A_TGT, 32'h3AA);
      @(negedge mclk) chk(tgt, 10'h000);
      w(A_CTL, 32'h4);
      @(negedge mclk) chk({mst, tgt}, {1'b1, 10'h02A});
      w(A_CTL, 32'h6);
      @(negedge mclk) chk(tgt, 10'h3AA);
      r(A_TGT, 32'h3AA);
   endtask

   // Reset again in mid-run; every field but mode10, master and the interrupt mask is checked to come back
   task automatic t_rerun();
      rst <= 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
   endtask

   // Verdict and end of run
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Main sequence after a three-cycle reset
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_protect();
      t_match7();
      t_mask();
      t_enable();
      t_ten();
      t_irq();
      t_target();
      t_rerun();
      conclude();
   end

   // Watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #400000;
      fail_count++;
      conclude();
   end
endmodule // i2cam_tb_top
`default_nettype wire
